//--- src/asb_status_bank.sv
// Status and bank-select register with its flag logic, file map and bus slave.
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module asb_status_bank
    import asb_pkg::*;
#(
    parameter int GPR_DEPTH = GPR_WORDS
) (
    input wire logic aclk, // Core clock, 40 MHz.
    input wire logic aresetn, // Synchronous reset, active low.
    input wire logic exec_valid, // One instruction executes this cycle.
    input wire asb_exec_type exec_req, // Operation, operands and destination.
    output logic [7:0] exec_result, // Result of the last executed operation.
    output logic exec_done, // Pulse one cycle after exec_valid.
    input wire logic watchdog_clear_instr, // Watchdog clear executed, pulse.
    input wire logic sleep_instr, // Sleep executed, pulse.
    input wire logic watchdog_timeout, // Watchdog timer expired, pulse.
    input wire logic rd_valid, // File read request.
    input wire logic [6:0] rd_addr, // File read address within the bank.
    output logic [7:0] rd_data, // File read data, one cycle later.
    output logic rd_done, // Pulse with rd_data.
    output asb_status_type status, // Live status register.
    output logic [7:0] file_select_pointer, // Live pointer register.
    input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr, // Write address.
    input wire logic s_axi_awvalid, // Write address valid.
    output logic s_axi_awready, // Write address ready.
    input wire logic [31:0] s_axi_wdata, // Write data.
    input wire logic [3:0] s_axi_wstrb, // Write byte enables.
    input wire logic s_axi_wvalid, // Write data valid.
    output logic s_axi_wready, // Write data ready.
    output logic [1:0] s_axi_bresp, // Write response.
    output logic s_axi_bvalid, // Write response valid.
    input wire logic s_axi_bready, // Write response ready.
    input wire logic [AXI_ADDR_W-1:0] s_axi_araddr, // Read address.
    input wire logic s_axi_arvalid, // Read address valid.
    output logic s_axi_arready, // Read address ready.
    output logic [31:0] s_axi_rdata, // Read data.
    output logic [1:0] s_axi_rresp, // Read response.
    output logic s_axi_rvalid, // Read data valid.
    input wire logic s_axi_rready // Read data ready.
);
    if (GPR_DEPTH != GPR_WORDS) begin : g_chk
        $error("asb_status_bank: GPR_DEPTH must match the file map");
    end

    // Direct addresses take the bank bit; address 00h goes through the pointer.
    function automatic logic [7:0] resolve(input logic [6:0] a, input logic bank,
                                           input logic [7:0] ptr);
        return (a == ADDR_INDIRECT) ? ptr : {bank, a};
    endfunction : resolve

    function automatic asb_tgt_type target_of(input logic [7:0] fa);
        if (fa == ADDR_STATUS_LO || fa == ADDR_STATUS_HI) begin
            return TGT_STATUS;
        end else if (fa == ADDR_FSR_LO || fa == ADDR_FSR_HI) begin
            return TGT_FSR;
        end else if ((fa >= GPR_BASE && fa <= GPR_TOP) || fa >= MIRROR_BASE) begin
            return TGT_RAM;
        end
        return TGT_NONE;
    endfunction : target_of

    function automatic logic [RAM_IDX_W-1:0] ram_index(input logic [7:0] fa);
        logic [7:0] base;
        base = (fa >= MIRROR_BASE) ? fa - BANK1_OFFSET : fa;
        return RAM_IDX_W'(base - GPR_BASE);
    endfunction : ram_index

    logic [7:0] exec_addr;
    asb_tgt_type exec_tgt;
    logic [7:0] alu_res;
    logic alu_c;
    logic alu_dc;
    logic alu_z;
    logic [2:0] aff;
    logic exec_st_hit;
    logic axi_st_fire;
    logic axi_fsr_fire;
    logic st_wr;
    logic st_flag_wr;
    logic [7:0] st_data;
    logic [7:0] rd_fa;
    asb_tgt_type rd_tgt;
    asb_tgt_type rd_tgt_q;
    logic [7:0] rd_reg_q;
    logic [7:0] ram_q;
    logic aw_held;
    logic w_held;
    logic [AXI_ADDR_W-1:0] aw_addr;
    logic [7:0] w_byte;
    logic w_lane;
    logic axi_wr_fire;

    assign exec_addr = resolve(exec_req.file_addr, status.direct_bank_select, file_select_pointer);
    assign exec_tgt = target_of(exec_addr);

    // Subtraction is b + ~a + 1, so carry set means no borrow.
    always_comb begin
        logic [7:0] y;
        logic cin;
        logic [8:0] sum;
        logic [4:0] nib;
        cin = (exec_req.op == OP_SUB);
        y = cin ? ~exec_req.operand_a : exec_req.operand_a;
        sum = {1'b0, exec_req.operand_b} + {1'b0, y} + {8'h00, cin};
        nib = {1'b0, exec_req.operand_b[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
        alu_res = exec_req.operand_a;
        alu_c = status.carry_flag;
        alu_dc = status.digit_carry_flag;
        aff = 3'b000;
        unique case (exec_req.op)
            OP_MOVE: alu_res = exec_req.operand_a;
            OP_CLEAR: begin
                alu_res = 8'h00;
                aff = 3'b100;
            end
            OP_ADD, OP_SUB: begin
                alu_res = sum[7:0];
                alu_c = sum[8];
                alu_dc = nib[4];
                aff = 3'b111;
            end
            OP_AND: begin
                alu_res = exec_req.operand_a & exec_req.operand_b;
                aff = 3'b100;
            end
            OP_OR: begin
                alu_res = exec_req.operand_a | exec_req.operand_b;
                aff = 3'b100;
            end
            OP_XOR: begin
                alu_res = exec_req.operand_a ^ exec_req.operand_b;
                aff = 3'b100;
            end
            OP_ROTL: begin
                alu_res = {exec_req.operand_b[6:0], status.carry_flag};
                alu_c = exec_req.operand_b[7];
                aff = 3'b001;
            end
            OP_ROTR: begin
                alu_res = {status.carry_flag, exec_req.operand_b[7:1]};
                alu_c = exec_req.operand_b[0];
                aff = 3'b001;
            end
            OP_SWAP: alu_res = {exec_req.operand_b[3:0], exec_req.operand_b[7:4]};
            OP_BCLR: begin
                alu_res = exec_req.operand_b;
                alu_res[exec_req.bit_sel] = 1'b0;
            end
            OP_BSET: begin
                alu_res = exec_req.operand_b;
                alu_res[exec_req.bit_sel] = 1'b1;
            end
            OP_PASS: begin
                alu_res = exec_req.operand_b;
                aff = 3'b100;
            end
            // Three op codes are unused; they act as a plain move and touch no flag.
            default: alu_res = exec_req.operand_a;
        endcase
        alu_z = (alu_res == 8'h00);
    end

    assign exec_st_hit = exec_valid && exec_req.to_file && exec_tgt == TGT_STATUS;
    // Bus writes wait for a cycle without an instruction so the two never collide.
    assign axi_wr_fire = aw_held && w_held && !s_axi_bvalid && !exec_valid;
    assign axi_st_fire = axi_wr_fire && w_lane && aw_addr[AXI_ADDR_W-1:2] == 6'(STATUS_INDEX);
    assign axi_fsr_fire = axi_wr_fire && w_lane && aw_addr[AXI_ADDR_W-1:2] == 6'(FSR_INDEX);
    assign st_wr = exec_st_hit || axi_st_fire;
    assign st_data = exec_st_hit ? alu_res : w_byte;
    assign st_flag_wr = axi_st_fire || (exec_st_hit && aff == 3'b000);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status <= STATUS_RESET;
        end else begin
            if (st_wr) begin
                status.indirect_bank_select <= 1'b0;
                status.upper_direct_bank_select <= st_data[6];
                status.direct_bank_select <= st_data[5];
            end
            if (exec_valid && aff[AFF_Z]) begin
                status.zero_flag <= alu_z;
            end else if (st_flag_wr) begin
                status.zero_flag <= st_data[2];
            end
            if (exec_valid && aff[AFF_DC]) begin
                status.digit_carry_flag <= alu_dc;
            end else if (st_flag_wr) begin
                status.digit_carry_flag <= st_data[1];
            end
            if (exec_valid && aff[AFF_C]) begin
                status.carry_flag <= alu_c;
            end else if (st_flag_wr) begin
                status.carry_flag <= st_data[0];
            end
            // Only hardware events reach these two bits; a timeout wins over a clear.
            if (watchdog_clear_instr) begin
                status.timeout_flag <= 1'b1;
                status.powerdown_flag <= 1'b1;
            end else if (sleep_instr) begin
                status.timeout_flag <= 1'b1;
                status.powerdown_flag <= 1'b0;
            end
            if (watchdog_timeout) begin
                status.timeout_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            file_select_pointer <= FSR_RESET;
        end else if (exec_valid && exec_req.to_file && exec_tgt == TGT_FSR) begin
            file_select_pointer <= alu_res;
        end else if (axi_fsr_fire) begin
            file_select_pointer <= w_byte;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            exec_result <= 8'h00;
            exec_done <= 1'b0;
        end else begin
            exec_done <= exec_valid;
            if (exec_valid) begin
                exec_result <= alu_res;
            end
        end
    end

    assign rd_fa = resolve(rd_addr, status.direct_bank_select, file_select_pointer);
    assign rd_tgt = target_of(rd_fa);

    asb_file_ram #(
        .WIDTH(8),
        .DEPTH(GPR_DEPTH),
        .IDX_W(RAM_IDX_W)
    ) u_ram (
        .clk(aclk),
        .wr_en(exec_valid && exec_req.to_file && exec_tgt == TGT_RAM),
        .wr_idx(ram_index(exec_addr)),
        .wr_data(alu_res),
        .rd_en(rd_valid && rd_tgt == TGT_RAM),
        .rd_idx(ram_index(rd_fa)),
        .rd_data(ram_q)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_tgt_q <= TGT_NONE;
            rd_reg_q <= 8'h00;
            rd_done <= 1'b0;
        end else begin
            rd_done <= rd_valid;
            if (rd_valid) begin
                rd_tgt_q <= rd_tgt;
                unique case (rd_tgt)
                    TGT_STATUS: rd_reg_q <= status;
                    TGT_FSR: rd_reg_q <= file_select_pointer;
                    TGT_RAM, TGT_NONE: rd_reg_q <= 8'h00;
                endcase
            end
        end
    end

    assign rd_data = (rd_tgt_q == TGT_RAM) ? ram_q : rd_reg_q;

    // Bus write side: address and data are taken in either order.
    assign s_axi_awready = !aw_held;
    assign s_axi_wready = !w_held;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_byte <= 8'h00;
            w_lane <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= AXI_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_byte <= s_axi_wdata[7:0];
                w_lane <= s_axi_wstrb[0];
            end
            if (axi_wr_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr[AXI_ADDR_W-1:2] == 6'(STATUS_INDEX)
                    || aw_addr[AXI_ADDR_W-1:2] == 6'(FSR_INDEX)) ? AXI_OKAY : AXI_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= AXI_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= AXI_OKAY;
            if (s_axi_araddr[AXI_ADDR_W-1:2] == 6'(STATUS_INDEX)) begin
                s_axi_rdata <= {24'h00_0000, status};
            end else if (s_axi_araddr[AXI_ADDR_W-1:2] == 6'(FSR_INDEX)) begin
                s_axi_rdata <= {24'h00_0000, file_select_pointer};
            end else begin
                s_axi_rdata <= 32'h0000_0000;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Checks below.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    asb_exec_type prev_req;
    always_ff @(posedge aclk) begin
        prev_req <= exec_req;
    end

    logic no_evt;
    assign no_evt = !watchdog_clear_instr && !sleep_instr && !watchdog_timeout;

    AST_TOPD_HW_ONLY: assert property (no_evt |=> $stable({status.timeout_flag,
        status.powerdown_flag})) else $error("timeout or powerdown changed without event");
    AST_CLEAR_STATUS: assert property (exec_st_hit && exec_req.op == OP_CLEAR && no_evt
        |=> status[7:5] == 3'b000 && status.zero_flag && $stable(status[4:3])
        && $stable(status[1:0])) else $error("clear of status gave wrong pattern");
    AST_ZERO_FLAG: assert property (exec_valid && aff[AFF_Z]
        |=> status.zero_flag == (exec_result == 8'h00)) else $error("zero flag wrong");
    AST_ADD_CARRY: assert property (exec_valid && exec_req.op == OP_ADD
        |=> status.carry_flag == (9'({1'b0, prev_req.operand_a}) + 9'({1'b0,
        prev_req.operand_b}) > 9'h0FF)) else $error("add carry wrong");
    AST_ADD_DIGIT: assert property (exec_valid && exec_req.op == OP_ADD
        |=> status.digit_carry_flag == (5'({1'b0, prev_req.operand_a[3:0]})
        + 5'({1'b0, prev_req.operand_b[3:0]}) > 5'h0F)) else $error("digit carry wrong");
    AST_SUB_BORROW: assert property (exec_valid && exec_req.op == OP_SUB
        |=> status.carry_flag == (prev_req.operand_b >= prev_req.operand_a)
        && exec_result == 8'(prev_req.operand_b - prev_req.operand_a))
        else $error("subtract borrow wrong");
    AST_ROTL_CARRY: assert property (exec_valid && exec_req.op == OP_ROTL
        |=> status.carry_flag == prev_req.operand_b[7]) else $error("rotate carry wrong");
    AST_SLEEP_FLAGS: assert property (sleep_instr && !watchdog_clear_instr
        && !watchdog_timeout |=> status.timeout_flag && !status.powerdown_flag)
        else $error("sleep flags wrong");
    AST_TIMEOUT: assert property (watchdog_timeout |=> !status.timeout_flag)
        else $error("timeout flag not cleared");
    AST_IRP_CLEAR: assert property (!status.indirect_bank_select)
        else $error("indirect bank select set");
    AST_STATUS_MIRROR: assert property (rd_valid && rd_tgt == TGT_STATUS
        |=> rd_done && rd_data == $past(status)) else $error("status read mismatch");
    AST_UNMAPPED_ZERO: assert property (rd_valid && rd_tgt == TGT_NONE
        |=> rd_data == 8'h00) else $error("unmapped read not zero");

    COV_CLEAR_STATUS: cover property (exec_st_hit && exec_req.op == OP_CLEAR);
    COV_SUB_BORROW: cover property (exec_valid && exec_req.op == OP_SUB ##1 !status.carry_flag);
    COV_SLEEP: cover property (sleep_instr ##1 !status.powerdown_flag);
    COV_BUS_WRITE: cover property (axi_st_fire ##1 s_axi_bvalid);
endmodule : asb_status_bank
`default_nettype wire

//--- src/asb_pkg.sv
// Constants and types shared by the status and bank-select register block.
package asb_pkg;
    // Data-memory map, 8-bit file addresses.
    localparam logic [6:0] ADDR_INDIRECT = 7'h00;
    localparam logic [7:0] ADDR_STATUS_LO = 8'h03;
    localparam logic [7:0] ADDR_STATUS_HI = 8'h83;
    localparam logic [7:0] ADDR_FSR_LO = 8'h04;
    localparam logic [7:0] ADDR_FSR_HI = 8'h84;
    localparam logic [7:0] GPR_BASE = 8'h20;
    localparam logic [7:0] GPR_TOP = 8'h7F;
    localparam logic [7:0] MIRROR_BASE = 8'hF0;
    localparam logic [7:0] BANK1_OFFSET = 8'h80;
    localparam int GPR_WORDS = 96;
    localparam int RAM_IDX_W = 7;
    // Register indices on the software bus; byte address is four times the index.
    localparam logic [7:0] STATUS_INDEX = 8'h03;
    localparam logic [7:0] FSR_INDEX = 8'h04;
    localparam int AXI_ADDR_W = 8;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
    // Values after reset.
    localparam logic [7:0] STATUS_RESET = 8'h18;
    localparam logic [7:0] FSR_RESET = 8'h00;
    // Flag-affect mask bit positions.
    localparam int AFF_Z = 2;
    localparam int AFF_DC = 1;
    localparam int AFF_C = 0;

    typedef enum logic [3:0] {
        OP_MOVE = 4'h0, OP_CLEAR = 4'h1, OP_ADD = 4'h2, OP_SUB = 4'h3,
        OP_AND = 4'h4, OP_OR = 4'h5, OP_XOR = 4'h6, OP_ROTL = 4'h7,
        OP_ROTR = 4'h8, OP_SWAP = 4'h9, OP_BCLR = 4'hA, OP_BSET = 4'hB,
        OP_PASS = 4'hC
    } asb_op_type;

    typedef enum logic [1:0] {
        TGT_NONE = 2'h0, TGT_STATUS = 2'h1, TGT_FSR = 2'h2, TGT_RAM = 2'h3
    } asb_tgt_type;

    typedef struct packed {
        logic indirect_bank_select;
        logic upper_direct_bank_select;
        logic direct_bank_select;
        logic timeout_flag;
        logic powerdown_flag;
        logic zero_flag;
        logic digit_carry_flag;
        logic carry_flag;
    } asb_status_type;

    typedef struct packed {
        asb_op_type op;
        logic [7:0] operand_a;
        logic [7:0] operand_b;
        logic [2:0] bit_sel;
        logic [6:0] file_addr;
        logic to_file;
    } asb_exec_type;
endpackage : asb_pkg

//--- src/asb_file_ram.sv
// General-purpose file RAM with one write port and a registered read port.
`timescale 1ns/10ps
`default_nettype none
module asb_file_ram #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 96,
    parameter int IDX_W = 7
) (
    input wire logic clk, // Core clock.
    input wire logic wr_en, // Write strobe.
    input wire logic [IDX_W-1:0] wr_idx, // Write index.
    input wire logic [WIDTH-1:0] wr_data, // Write data.
    input wire logic rd_en, // Read strobe.
    input wire logic [IDX_W-1:0] rd_idx, // Read index.
    output logic [WIDTH-1:0] rd_data // Read data, one cycle after rd_en.
);
    logic [WIDTH-1:0] mem [DEPTH];

    if (DEPTH > (1 << IDX_W)) begin : g_chk
        $error("asb_file_ram: DEPTH does not fit IDX_W");
    end

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_idx] <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rd_en) begin
            rd_data <= mem[rd_idx];
        end
    end
endmodule : asb_file_ram
`default_nettype wire

//--- test/asb_core_model.sv
// Behavioural model of the instruction core that drives the status block.
`timescale 1ns/10ps
`default_nettype none
module asb_core_model
    import asb_pkg::*;
(
    input wire logic aclk, // Core clock.
    input wire logic exec_done, // Execute ack.
    input wire logic rd_done, // Read ack.
    input wire logic [7:0] rd_data, // Read data.
    output logic exec_valid, // Execute strobe.
    output var asb_exec_type exec_req, // Instruction.
    output logic watchdog_clear_instr, // Clear pulse.
    output logic sleep_instr, // Sleep pulse.
    output logic watchdog_timeout, // Expiry pulse.
    output logic rd_valid, // Read strobe.
    output logic [6:0] rd_addr // Read address.
);
    initial {exec_valid, exec_req, watchdog_clear_instr, sleep_instr, watchdog_timeout} = '0;
    initial {rd_valid, rd_addr} = '0;
    task automatic run(input asb_op_type k, input logic [7:0] a, input logic [7:0] b,
                       input logic [6:0] fa, input logic tf, output logic ok);
        logic [7:0] w;
        w = a;
        // Status writes keep both reserved bank bits clear.
        if (tf && fa == 7'h03) w[7:6] = 2'b00;
        exec_req <= '{k, w, b, 3'h0, fa, tf};
        exec_valid <= 1'b1;
        @(posedge aclk);
        exec_valid <= 1'b0;
        // Inverted once taken, so stale fields never pass as a match.
        exec_req <= asb_exec_type'(~exec_req);
        @(posedge aclk);
        ok = exec_done;
    endtask : run
    task automatic fetch(input logic [6:0] a, output logic [7:0] d, output logic ok);
        rd_valid <= 1'b1;
        rd_addr <= a;
        @(posedge aclk);
        rd_valid <= 1'b0;
        rd_addr <= ~a;
        @(posedge aclk);
        d = rd_data;
        ok = rd_done;
    endtask : fetch
    task automatic pulse(input logic [2:0] e);
        {watchdog_clear_instr, sleep_instr, watchdog_timeout} <= e;
        @(posedge aclk);
        {watchdog_clear_instr, sleep_instr, watchdog_timeout} <= 3'b000;
        @(posedge aclk);
    endtask : pulse
endmodule : asb_core_model
`default_nettype wire

//--- test/test_alu_status_bank_select.sv
// Self-checking testbench for the status and bank-select register block.
`timescale 1ns/10ps
`default_nettype none
module test_alu_status_bank_select
    import asb_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic exec_valid, exec_done, rd_valid, rd_done, sleep_instr;
    logic watchdog_clear_instr, watchdog_timeout;
    logic [7:0] exec_result, rd_data, file_select_pointer;
    logic [6:0] rd_addr;
    asb_exec_type exec_req;
    asb_status_type status;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [31:0] s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int err_total = 0;
    int num_checks = 0;
    always #12.5 aclk = ~aclk;
    asb_status_bank dut (.aclk, .aresetn, .exec_valid, .exec_req, .exec_result, .exec_done,
        .watchdog_clear_instr, .sleep_instr, .watchdog_timeout, .rd_valid, .rd_addr, .rd_data,
        .rd_done, .status, .file_select_pointer, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    asb_core_model core (.aclk, .exec_done, .rd_done, .rd_data, .exec_valid, .exec_req,
        .watchdog_clear_instr, .sleep_instr, .watchdog_timeout, .rd_valid, .rd_addr);
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run
    task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [1:0] r, output logic [31:0] q);
        int n;
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
        {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (wr ? s_axi_bvalid : s_axi_rvalid) break;
        end
        {s_axi_bready, s_axi_rready} <= 2'b00;
        r = wr ? s_axi_bresp : s_axi_rresp;
        q = s_axi_rdata;
        if (n == 40) begin
            err_total++;
            complete_run();
        end
        @(posedge aclk);
    endtask : axi
    task automatic test_flags();
        logic [35:0] t[13] = '{36'h2_0F01_101A, 36'h2_FF01_001F, 36'h3_0305_021B,
            36'h3_0503_FE18, 36'h7_0080_0019, 36'h8_0001_8019, 36'h4_F00F_001D,
            36'h5_F00F_FF19, 36'h6_FFFF_001D, 36'h9_00A5_5A1D, 36'hA_00FF_FE1D,
            36'hB_0000_011D, 36'hC_003C_3C19};
        logic ok;
        for (int i = 0; i < 13; i++) begin
            core.run(asb_op_type'(t[i][35:32]), t[i][31:24], t[i][23:16], 7'h00, 1'b0, ok);
            check("exec_done", {7'h00, ok}, 8'h01);
            check("exec_result", exec_result, t[i][15:8]);
            check("status", status, t[i][7:0]);
        end
    endtask : test_flags
    task automatic test_status_write();
        logic ok;
        core.run(OP_MOVE, 8'h25, 8'h00, 7'h03, 1'b1, ok);
        check("status", status, 8'h3D);
        core.run(OP_ADD, 8'h01, 8'h02, 7'h03, 1'b1, ok);
        check("status", status, 8'h18);
        core.run(OP_MOVE, 8'h22, 8'h00, 7'h03, 1'b1, ok);
        core.run(OP_CLEAR, 8'h00, 8'h00, 7'h03, 1'b1, ok);
        check("status", status, 8'h1E);
        core.pulse(3'b001);
        check("status", status, 8'h0E);
        core.pulse(3'b010);
        check("status", status, 8'h16);
        core.pulse(3'b100);
        check("status", status, 8'h1E);
    endtask : test_status_write
    task automatic test_map();
        logic [6:0] ra[5] = '{7'h70, 7'h03, 7'h00, 7'h20, 7'h04};
        logic [7:0] re[5] = '{8'h5A, 8'h38, 8'h5A, 8'h00, 8'h70};
        logic [7:0] d;
        logic ok;
        core.run(OP_MOVE, 8'h5A, 8'h00, 7'h70, 1'b1, ok);
        core.run(OP_MOVE, 8'h70, 8'h00, 7'h04, 1'b1, ok);
        check("pointer", file_select_pointer, 8'h70);
        core.run(OP_MOVE, 8'h20, 8'h00, 7'h03, 1'b1, ok);
        for (int i = 0; i < 5; i++) begin
            core.fetch(ra[i], d, ok);
            check("rd_done", {7'h00, ok}, 8'h01);
            check("rd_data", d, re[i]);
        end
    endtask : test_map
    task automatic test_axi();
        logic [31:0] q;
        logic [1:0] r;
        logic [7:0] d;
        logic ok;
        axi(1'b0, 8'h0C, 32'h0000_0000, r, q);
        check("rdata", q[7:0], 8'h38);
        check("rresp", {6'h00, r}, {6'h00, AXI_OKAY});
        axi(1'b1, 8'h0C, 32'h0000_00FF, r, q);
        check("bresp", {6'h00, r}, {6'h00, AXI_OKAY});
        check("status", status, 8'h7F);
        axi(1'b1, 8'h40, 32'h0000_0000, r, q);
        check("bresp", {6'h00, r}, {6'h00, AXI_SLVERR});
        axi(1'b0, 8'h40, 32'h0000_0000, r, q);
        check("rdata", q[7:0], 8'h00);
        axi(1'b1, 8'h10, 32'h0000_0003, r, q);
        check("bresp", {6'h00, r}, {6'h00, AXI_OKAY});
        check("pointer", file_select_pointer, 8'h03);
        // A write with byte 0 disabled is answered but must leave the pointer alone.
        s_axi_wstrb <= 4'h0;
        axi(1'b1, 8'h10, 32'h0000_0099, r, q);
        s_axi_wstrb <= 4'hF;
        check("bresp", {6'h00, r}, {6'h00, AXI_OKAY});
        check("pointer", file_select_pointer, 8'h03);
        axi(1'b0, 8'h10, 32'h0000_0000, r, q);
        check("rdata", q[7:0], 8'h03);
        core.fetch(7'h00, d, ok);
        check("rd_data", d, 8'h7F);
    endtask : test_axi
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check("status", status, 8'h18);
        test_flags();
        test_status_write();
        test_map();
        test_axi();
        complete_run();
    end
    initial begin
        repeat (20000) @(posedge aclk);
        err_total++;
        complete_run();
    end
endmodule : test_alu_status_bank_select
`default_nettype wire
